//--- pkg/tsc_params.svh
// constants of the touch sampling configuration block
// Notes on behaviour
// R1 - four-bit oversample factor, valid 1 to 15
// R2 - oversample resets to 7; more samples, more power
// R3 - charge field times six clocks drives charge
// R4 - charge resets to 6000, 36000 clock charge
// R5 - adc bit: 0 single-ended, 1 differential, default
// R6 - four-bit settle field resets 3, wait before sampling
// R7 - mode: off, single, per frame, continuous default
// R8 - new settings apply from next measurement only; a write of mode off stops the running one at once
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

`define TSC_ADDR_STATUS 32'h001024EC
`define TSC_ADDR_MODE 32'h001024F0
`define TSC_ADDR_ADC_MODE 32'h001024F4
`define TSC_ADDR_CHARGE 32'h001024F8
`define TSC_ADDR_SETTLE 32'h001024FC
`define TSC_ADDR_OVERSAMPLE 32'h00102500

`define TSC_RST_MODE 2'h3
`define TSC_RST_ADC_MODE 1'h1
`define TSC_RST_CHARGE 16'h1770
`define TSC_RST_SETTLE 4'h3
`define TSC_RST_OVERSAMPLE 4'h7

`define TSC_MODE_OFF 2'h0
`define TSC_MODE_SINGLE 2'h1
`define TSC_MODE_FRAME 2'h2
`define TSC_MODE_CONT 2'h3

`define TSC_CHARGE_UNIT 3'h6

`define TSC_RESP_OKAY 2'h0
`define TSC_RESP_SLVERR 2'h2

`endif

//--- pkg/tsc_pkg.sv
// types shared by the touch sampling configuration block
package tsc_pkg;

  typedef enum logic [1:0] {PH_IDLE, PH_CHARGE, PH_SETTLE, PH_SAMPLE} tsc_phase_t;

  typedef struct packed {
    logic adc_diff;
    logic [3:0] settle;
    logic [15:0] charge;
    logic [3:0] oversample;
  } tsc_cfg_t;

  // zero is not a usable count; it is treated as one
  function automatic logic [15:0] tsc_nonzero(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0001 : v;
  endfunction : tsc_nonzero

endpackage : tsc_pkg

//--- hdl/tsc_seq.sv
// touch measurement sequencer: charge, settle and sample phases
`timescale 1ns/1ps
`include "tsc_params.svh"
module tsc_seq (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire tsc_pkg::tsc_cfg_t cfg,
  output logic busy_q,
  output tsc_pkg::tsc_phase_t state_q,
  output logic panel_charge_q,
  output logic adc_sample_q,
  output logic adc_diff_q,
  output logic done_q
);
  tsc_pkg::tsc_phase_t state_d;
  tsc_pkg::tsc_cfg_t cfg_q;
  logic [15:0] cnt_q;
  logic [2:0] div_q;
  logic [3:0] left_q;
  logic [19:0] chg_len_q;
  logic [3:0] smp_cnt_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      tsc_pkg::PH_IDLE: if (start) state_d = tsc_pkg::PH_CHARGE;
      tsc_pkg::PH_CHARGE:
        if (div_q == `TSC_CHARGE_UNIT - 3'h1 && cnt_q == cfg_q.charge - 16'h0001) // R3
          state_d = (cfg_q.settle == 4'h0) ? tsc_pkg::PH_SAMPLE : tsc_pkg::PH_SETTLE;
      tsc_pkg::PH_SETTLE:
        if (cnt_q == {12'h000, cfg_q.settle} - 16'h0001) state_d = tsc_pkg::PH_SAMPLE; // R6
      tsc_pkg::PH_SAMPLE:
        state_d = (left_q == 4'h1) ? tsc_pkg::PH_IDLE : tsc_pkg::PH_CHARGE; // R1
      default: state_d = tsc_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= tsc_pkg::PH_IDLE;
      busy_q <= 1'b0;
      panel_charge_q <= 1'b0;
      adc_sample_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      busy_q <= (state_d != tsc_pkg::PH_IDLE);
      panel_charge_q <= (state_d == tsc_pkg::PH_CHARGE); // R3
      adc_sample_q <= (state_d == tsc_pkg::PH_SAMPLE);
      done_q <= (state_q == tsc_pkg::PH_SAMPLE) && (left_q == 4'h1);
    end
  end

  // settings are snapshotted at start so a write mid-measurement cannot tear it
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_q <= '0;
      adc_diff_q <= 1'b0;
      left_q <= 4'h0;
    end
    else if (state_q == tsc_pkg::PH_IDLE && start)
    begin
      cfg_q.adc_diff <= cfg.adc_diff; // R8
      cfg_q.settle <= cfg.settle;
      cfg_q.charge <= tsc_pkg::tsc_nonzero(cfg.charge);
      cfg_q.oversample <= 4'(tsc_pkg::tsc_nonzero({12'h000, cfg.oversample})); // R1
      adc_diff_q <= cfg.adc_diff; // R5
      left_q <= 4'(tsc_pkg::tsc_nonzero({12'h000, cfg.oversample}));
    end
    else if (state_q == tsc_pkg::PH_SAMPLE)
      left_q <= left_q - 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset || state_d != state_q || state_q == tsc_pkg::PH_IDLE)
    begin
      cnt_q <= 16'h0000;
      div_q <= 3'h0;
    end
    else if (state_q == tsc_pkg::PH_CHARGE)
    begin
      div_q <= (div_q == `TSC_CHARGE_UNIT - 3'h1) ? 3'h0 : div_q + 3'h1;
      if (div_q == `TSC_CHARGE_UNIT - 3'h1) cnt_q <= cnt_q + 16'h0001;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  // helper counters read only by the checks below
  always_ff @(posedge clk)
  begin
    if (reset || !panel_charge_q) chg_len_q <= 20'h00000;
    else chg_len_q <= chg_len_q + 20'h00001;
    if (reset || (state_q == tsc_pkg::PH_IDLE && start)) smp_cnt_q <= 4'h0;
    else if (adc_sample_q) smp_cnt_q <= smp_cnt_q + 4'h1;
  end

  chk_charge_length: assert property (@(posedge clk) disable iff (reset) // R3
    $fell(panel_charge_q) && !$past(reset) |-> chg_len_q == 20'(cfg_q.charge) * 20'h00006)
    else $error("charge phase length is not six clocks per unit");
  chk_settle_wait: assert property (@(posedge clk) disable iff (reset) // R6
    (state_q == tsc_pkg::PH_SAMPLE && $past(state_q) == tsc_pkg::PH_SETTLE)
    |-> $past(cnt_q) == {12'h000, cfg_q.settle} - 16'h0001)
    else $error("settle wait does not match settle field");
  chk_sample_count: assert property (@(posedge clk) disable iff (reset) // R1
    done_q |-> smp_cnt_q == cfg_q.oversample)
    else $error("sample count differs from oversample factor");
  chk_cfg_held: assert property (@(posedge clk) disable iff (reset) // R8
    busy_q && $past(busy_q) |-> $stable(cfg_q) && $stable(adc_diff_q))
    else $error("settings changed during a measurement");
  chk_diff_follow: assert property (@(posedge clk) disable iff (reset) // R5
    $rose(busy_q) |-> adc_diff_q == $past(cfg.adc_diff))
    else $error("adc mode differs from captured setting");
endmodule : tsc_seq

//--- hdl/tsc_top.sv
// touch sampling configuration registers with an axi4-lite slave
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "tsc_params.svh"
module tsc_top #(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_tick,
  output logic panel_charge,
  output logic adc_sample,
  output logic adc_diff,
  output logic meas_done,
  output logic touch_busy
);
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q;
  logic w_held_q;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [1:0] mode_q;
  logic adc_diff_q;
  logic [15:0] charge_q;
  logic [3:0] settle_q;
  logic [3:0] oversample_q;
  logic single_pend_q;
  logic [7:0] meas_cnt_q;
  logic start;
  logic seq_reset;
  logic [31:0] wr_old;
  logic [31:0] wr_new;
  tsc_pkg::tsc_cfg_t cfg;
  tsc_pkg::tsc_phase_t phase;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) r[8*i +: 8] = data[8*i +: 8];
    return r;
  endfunction : merge

  // address and data may arrive in either order; each is parked until both are here
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TSC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `TSC_RESP_OKAY : `TSC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_comb
  begin
    case (awaddr_q)
      ADDR_W'(`TSC_ADDR_STATUS), ADDR_W'(`TSC_ADDR_MODE), ADDR_W'(`TSC_ADDR_ADC_MODE),
      ADDR_W'(`TSC_ADDR_CHARGE), ADDR_W'(`TSC_ADDR_SETTLE),
      ADDR_W'(`TSC_ADDR_OVERSAMPLE): wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // old contents of the addressed register, so bytes without a strobe keep their value
  always_comb
  begin
    case (awaddr_q)
      ADDR_W'(`TSC_ADDR_MODE): wr_old = {30'h0, mode_q};
      ADDR_W'(`TSC_ADDR_ADC_MODE): wr_old = {31'h0, adc_diff_q};
      ADDR_W'(`TSC_ADDR_CHARGE): wr_old = {16'h0000, charge_q};
      ADDR_W'(`TSC_ADDR_SETTLE): wr_old = {28'h0, settle_q};
      ADDR_W'(`TSC_ADDR_OVERSAMPLE): wr_old = {28'h0, oversample_q};
      default: wr_old = 32'h00000000;
    endcase
    wr_new = merge(wr_old, wdata_q, wstrb_q);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_q <= `TSC_RST_MODE; // R7
      adc_diff_q <= `TSC_RST_ADC_MODE; // R5
      charge_q <= `TSC_RST_CHARGE; // R4
      settle_q <= `TSC_RST_SETTLE; // R6
      oversample_q <= `TSC_RST_OVERSAMPLE; // R2
    end
    else if (wr_fire)
    begin
      case (awaddr_q)
        ADDR_W'(`TSC_ADDR_MODE): mode_q <= wr_new[1:0];
        ADDR_W'(`TSC_ADDR_ADC_MODE): adc_diff_q <= wr_new[0]; // R5
        ADDR_W'(`TSC_ADDR_CHARGE): charge_q <= wr_new[15:0]; // R3
        ADDR_W'(`TSC_ADDR_SETTLE): settle_q <= wr_new[3:0]; // R6
        ADDR_W'(`TSC_ADDR_OVERSAMPLE): oversample_q <= wr_new[3:0]; // R1
        default: ;
      endcase
    end
  end

  // a single request written in the cycle it is consumed is kept: set beats clear
  always_ff @(posedge clk)
  begin
    if (reset)
      single_pend_q <= 1'b0;
    else if (wr_fire && awaddr_q == ADDR_W'(`TSC_ADDR_MODE) && wstrb_q[0]
             && wdata_q[1:0] == `TSC_MODE_SINGLE)
      single_pend_q <= 1'b1; // R7
    else if (start && mode_q == `TSC_MODE_SINGLE)
      single_pend_q <= 1'b0;
  end

  // frame ticks that land during a measurement are dropped, not queued
  always_comb
  begin
    case (mode_q)
      `TSC_MODE_SINGLE: start = !touch_busy && single_pend_q; // R7
      `TSC_MODE_FRAME: start = !touch_busy && frame_tick;
      `TSC_MODE_CONT: start = !touch_busy;
      default: start = 1'b0;
    endcase
  end

  // off halts a running measurement at once; the other settings wait for the next start
  assign seq_reset = reset || (mode_q == `TSC_MODE_OFF); // R7

  assign cfg = '{adc_diff: adc_diff_q, settle: settle_q, charge: charge_q,
                 oversample: oversample_q};

  tsc_seq u_seq (
    .clk(clk),
    .reset(seq_reset),
    .start(start),
    .cfg(cfg),
    .busy_q(touch_busy),
    .state_q(phase),
    .panel_charge_q(panel_charge),
    .adc_sample_q(adc_sample),
    .adc_diff_q(adc_diff),
    .done_q(meas_done)
  );

  always_ff @(posedge clk)
  begin
    if (reset) meas_cnt_q <= 8'h00;
    else if (meas_done) meas_cnt_q <= meas_cnt_q + 8'h01;
  end

  always_comb
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_W'(`TSC_ADDR_STATUS): rd_data = {16'h0000, meas_cnt_q, 5'h00, phase, touch_busy};
      ADDR_W'(`TSC_ADDR_MODE): rd_data = {30'h0, mode_q};
      ADDR_W'(`TSC_ADDR_ADC_MODE): rd_data = {31'h0, adc_diff_q};
      ADDR_W'(`TSC_ADDR_CHARGE): rd_data = {16'h0000, charge_q};
      ADDR_W'(`TSC_ADDR_SETTLE): rd_data = {28'h0, settle_q};
      ADDR_W'(`TSC_ADDR_OVERSAMPLE): rd_data = {28'h0, oversample_q};
      default:
      begin
        rd_data = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TSC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? `TSC_RESP_OKAY : `TSC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  chk_reset_defaults: assert property (@(posedge clk) disable iff (reset) // R2
    $past(reset) |-> oversample_q == 4'h7 && charge_q == 16'h1770 && settle_q == 4'h3
      && adc_diff_q && mode_q == 2'h3)
    else $error("register defaults wrong after reset");
  chk_first_charge: assert property (@(posedge clk) disable iff (reset) // R4
    $past(reset) |-> ##1 panel_charge [*8])
    else $error("default charge phase did not start at once");
  chk_mode_off: assert property (@(posedge clk) disable iff (reset) // R7
    mode_q == 2'h0 |=> !touch_busy && !adc_sample)
    else $error("sampling started while mode is off");
  chk_cont_restart: assert property (@(posedge clk) disable iff (reset) // R7
    mode_q == 2'h3 && !touch_busy |=> touch_busy)
    else $error("continuous mode did not restart");
  chk_write_resp: assert property (@(posedge clk) disable iff (reset)
    aw_held_q && w_held_q && !s_axi_bvalid |=> s_axi_bvalid && !aw_held_q)
    else $error("write response not raised after address and data");
endmodule : tsc_top

//--- test/tsc_panel_model.sv
// resistive panel model: measures the charge, settle and sample timing it is driven with
`timescale 1ns/1ps
module tsc_panel_model (
  input wire logic clk,
  input wire logic panel_charge,
  input wire logic adc_sample,
  input wire logic adc_diff,
  output logic [31:0] charge_len,
  output logic [31:0] settle_gap,
  output logic [31:0] samples,
  output logic diff_seen
);
  logic [31:0] run_q = 32'h0;
  logic [31:0] gap_q = 32'h0;
  initial charge_len = 32'h0;
  initial settle_gap = 32'h0;
  initial samples = 32'h0;
  initial diff_seen = 1'b0;
  // the panel charges only while driven; length kept once the drive drops
  always @(posedge clk)
  begin
    if (panel_charge)
      run_q <= run_q + 32'h1;
    else if (run_q != 32'h0)
    begin
      charge_len <= run_q;
      run_q <= 32'h0;
    end
  end
  // idle cycles between charge end and the sample strobe
  always @(posedge clk)
  begin
    if (panel_charge)
      gap_q <= 32'h0;
    else if (!adc_sample)
      gap_q <= gap_q + 32'h1;
    if (adc_sample)
    begin
      samples <= samples + 32'h1;
      settle_gap <= gap_q;
      diff_seen <= adc_diff;
    end
  end
endmodule : tsc_panel_model

//--- test/testbench.sv
// self-checking bench for the touch sampling configuration block
`timescale 1ns/1ps
`include "tsc_params.svh"
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic frame_tick = 1'b0;
  logic panel_charge, adc_sample, adc_diff, meas_done, touch_busy;
  logic [31:0] charge_len, settle_gap, samples;
  logic diff_seen;
  logic [31:0] s0;
  logic [31:0] rd;
  logic [1:0] rsp;
  int n_fail = 0;
  int comparisons = 0;

  always #50 clk = ~clk;

  tsc_top #(.ADDR_W(32)) tsc_top_i (.clk(clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .frame_tick(frame_tick),
    .panel_charge(panel_charge), .adc_sample(adc_sample), .adc_diff(adc_diff),
    .meas_done(meas_done), .touch_busy(touch_busy));

  tsc_panel_model tsc_panel_model_i (.clk(clk), .panel_charge(panel_charge),
    .adc_sample(adc_sample), .adc_diff(adc_diff), .charge_len(charge_len),
    .settle_gap(settle_gap), .samples(samples), .diff_seen(diff_seen));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic give_up(input string what);
    n_fail++;
    $display("[ERR] %0t timeout %s", $time, what);
    summarize();
  endtask : give_up

  // outputs read right after an edge still show their pre-edge values
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 100)
        give_up("write");
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 100)
        give_up("read");
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd

  task automatic wr_ok(input logic [31:0] a, input logic [31:0] d);
    axi_wr(a, d, rsp);
    chk({30'h0, rsp}, 32'h0, "write response");
  endtask : wr_ok

  // sel 0 waits for the done pulse, sel 1 for the charge drive to drop
  task automatic wait_for(input int sel, input int bound);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > bound)
        give_up("wait");
    end while (sel == 0 ? meas_done !== 1'b1 : panel_charge !== 1'b0);
  endtask : wait_for

  task automatic t_defaults();
    axi_rd(`TSC_ADDR_MODE, rd, rsp);
    chk(rd, 32'h3, "mode reset");
    axi_rd(`TSC_ADDR_ADC_MODE, rd, rsp);
    chk(rd, 32'h1, "adc mode reset");
    axi_rd(`TSC_ADDR_CHARGE, rd, rsp);
    chk(rd, 32'h1770, "charge reset");
    axi_rd(`TSC_ADDR_SETTLE, rd, rsp);
    chk(rd, 32'h3, "settle reset");
    axi_rd(`TSC_ADDR_OVERSAMPLE, rd, rsp);
    chk(rd, 32'h7, "oversample reset");
    axi_rd(32'h00102600, rd, rsp);
    chk(rd, 32'h0, "unmapped read data");
    chk({30'h0, rsp}, 32'h2, "unmapped read response");
    chk({31'h0, touch_busy}, 32'h1, "continuous after reset");
    chk({31'h0, adc_diff}, 32'h1, "differential after reset");
    $display("test defaults done");
  endtask : t_defaults

  // settings change mid-measurement; the running one keeps the old ones until off stops it
  task automatic t_live_change();
    wr_ok(`TSC_ADDR_CHARGE, 32'h1);
    wr_ok(`TSC_ADDR_SETTLE, 32'h2);
    wr_ok(`TSC_ADDR_OVERSAMPLE, 32'h2);
    wr_ok(`TSC_ADDR_ADC_MODE, 32'h0);
    axi_wr(32'h00102600, 32'h5, rsp);
    chk({30'h0, rsp}, 32'h2, "unmapped write");
    axi_rd(`TSC_ADDR_SETTLE, rd, rsp);
    chk(rd, 32'h2, "settle readback");
    chk({31'h0, adc_diff}, 32'h1, "running adc mode kept");
    wait_for(1, 40000);
    @(posedge clk);
    @(posedge clk);
    chk(charge_len, 32'h8CA0, "default charge length");
    // past the default settle and the first sample, into the next long charge
    repeat (4) @(posedge clk);
    chk(samples, 32'h1, "first sample taken");
    chk({31'h0, diff_seen}, 32'h1, "old adc mode kept");
    wr_ok(`TSC_ADDR_MODE, 32'h0);
    repeat (20) @(posedge clk);
    chk({31'h0, touch_busy}, 32'h0, "stopped mode idle");
    chk(samples, 32'h1, "off stops sampling");
    $display("test live change done");
  endtask : t_live_change

  task automatic t_single();
    s0 = samples;
    wr_ok(`TSC_ADDR_MODE, 32'h1);
    wait_for(0, 200);
    chk(samples - s0, 32'h2, "two samples");
    chk(charge_len, 32'h6, "charge one unit");
    chk(settle_gap, 32'h2, "settle gap");
    chk({31'h0, diff_seen}, 32'h0, "single ended");
    repeat (50) @(posedge clk);
    chk({31'h0, touch_busy}, 32'h0, "single runs once");
    $display("test single done");
  endtask : t_single

  task automatic t_frame();
    wr_ok(`TSC_ADDR_OVERSAMPLE, 32'hF);
    wr_ok(`TSC_ADDR_ADC_MODE, 32'h1);
    wr_ok(`TSC_ADDR_MODE, 32'h2);
    repeat (20) @(posedge clk);
    chk({31'h0, touch_busy}, 32'h0, "frame mode waits");
    s0 = samples;
    frame_tick <= 1'b1;
    @(posedge clk);
    frame_tick <= 1'b0;
    wait_for(0, 400);
    chk(samples - s0, 32'hF, "fifteen samples");
    chk({31'h0, diff_seen}, 32'h1, "differential");
    wr_ok(`TSC_ADDR_MODE, 32'h3);
    wait_for(0, 400);
    wait_for(0, 400);
    chk(samples - s0, 32'h2D, "continuous repeats");
    $display("test frame done");
  endtask : t_frame

  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_defaults();
    t_live_change();
    t_single();
    t_frame();
    summarize();
  end
endmodule : testbench
